// [verilog/ccp_pin_ctrl.sv]
// Serial host pin steering, reset, output disable and status pins
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for a group of pin levels
module ccp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous levels in, synchronous levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two stages, first stage read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : ccp_sync

module ccp_pin_ctrl
  import ccp_pkg::*;
(
  // Clock and system reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Reset pin
  input wire logic i_device_reset_n,
  // Protocol strap and serial clock
  input wire logic i_i2c_select,
  input wire logic i_sclk,
  // Shared data pin
  input wire logic i_serial_data,
  output logic o_serial_data,
  output logic o_serial_data_oe,
  // Address-one or serial data out pin
  input wire logic i_addr_one_or_serial_out,
  output logic o_addr_one_or_serial_out,
  output logic o_addr_one_or_serial_out_oe,
  // Address-zero or select pin
  input wire logic i_addr_zero_or_select_n,
  // Output disable pin
  input wire logic i_outputs_disable,
  // Core side: bus configuration and transmit data
  input wire logic i_spi_four_wire,
  input wire logic i_tx_bit,
  input wire logic i_tx_en,
  // Core side: bus view
  output logic o_bus_is_i2c,
  output logic [CCP_ADDR_PINS-1:0] o_i2c_addr_pins,
  output logic o_spi_selected,
  output logic o_sclk_rise,
  output logic o_sclk_fall,
  output logic o_serial_in,
  // Core side: reset to register defaults
  output logic o_core_reset,
  // Core side: clock output control
  input wire logic [CCP_NUM_OUTS-1:0] i_out_cfg_enable,
  output logic [CCP_NUM_OUTS-1:0] o_clk_out_enable,
  // Core side: status sources and interrupt clear
  input wire logic i_pll_locked,
  input wire logic [CCP_NUM_LOS-1:0] i_input_lost,
  input wire logic i_irq_clear,
  // Status pins
  output logic o_status_change_irq_n,
  output logic o_lock_ok_indicator,
  output logic o_input0_signal_loss_n,
  output logic o_input1_signal_loss_n,
  output logic o_input2_signal_loss_n
);

  // Reset combination and release synchroniser
  logic rst_async;
  logic [1:0] rst_sync_reg;
  logic core_rst;

  // Synchronised pins
  logic [CCP_NUM_PINS-1:0] pin_async;
  logic [CCP_NUM_PINS-1:0] pin_s;

  // Straps caught after reset release
  logic strap_done_reg, strap_done_next;
  logic mode_i2c_reg, mode_i2c_next;
  logic [CCP_ADDR_PINS-1:0] addr_reg, addr_next;
  logic [1:0] strap_wait_reg, strap_wait_next;

  // Serial bus sampling
  logic sclk_d_reg, sclk_d_next;
  logic serial_in_reg, serial_in_next;
  logic selected;

  // Pin drive registers
  logic data_out_reg, data_out_next;
  logic data_oe_reg, data_oe_next;
  logic so_out_reg, so_out_next;
  logic so_oe_reg, so_oe_next;

  // Status tracking
  logic [CCP_STAT_W-1:0] stat_now;
  logic [CCP_STAT_W-1:0] stat_reg, stat_next;
  logic stat_valid_reg, stat_valid_next;
  logic irq_reg, irq_next;
  logic status_event;

  // Clock output enables
  logic [CCP_NUM_OUTS-1:0] outs_reg, outs_next;

  // Either reset source asserts at once
  assign rst_async = i_rst | ~i_device_reset_n;

  // Release resynchronised to the clock
  always_ff @(posedge i_clk or posedge rst_async) begin
    if (rst_async) begin
      rst_sync_reg <= CCP_RST_SYNC_INIT;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h0};
    end
  end

  assign core_rst = rst_sync_reg[1];

  // Pin levels gathered for synchronisation
  always_comb begin
    pin_async = CCP_PIN_RST;
    pin_async[CCP_PIN_STRAP] = i_i2c_select;
    pin_async[CCP_PIN_DATA] = i_serial_data;
    pin_async[CCP_PIN_ADDR1] = i_addr_one_or_serial_out;
    pin_async[CCP_PIN_SCLK] = i_sclk;
    pin_async[CCP_PIN_ADDR0] = i_addr_zero_or_select_n;
    pin_async[CCP_PIN_ODIS] = i_outputs_disable;
  end

  // Every pin passes two flip-flops
  ccp_sync #(
    .WIDTH(CCP_NUM_PINS)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(core_rst),
    .i_async(pin_async),
    .o_sync(pin_s)
  );

  // Strap and address pins caught once after release
  always_comb begin
    strap_done_next = strap_done_reg;
    mode_i2c_next = mode_i2c_reg;
    addr_next = addr_reg;
    strap_wait_next = strap_wait_reg;
    if (!strap_done_reg) begin
      if (strap_wait_reg != 2'(CCP_SYNC_STAGES)) begin
        // Synchroniser still holds its reset value, wait for real levels
        strap_wait_next = strap_wait_reg + 2'h1;
      end else begin
        strap_done_next = 1'h1;
        mode_i2c_next = (pin_s[CCP_PIN_STRAP] == CCP_STRAP_I2C);
        addr_next[1] = pin_s[CCP_PIN_ADDR1];
        addr_next[0] = pin_s[CCP_PIN_ADDR0];
      end
    end
  end

  // Strap registers
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      strap_done_reg <= 1'h0;
      strap_wait_reg <= 2'h0;
      mode_i2c_reg <= 1'h0;
      addr_reg <= CCP_ADDR_RST;
    end else begin
      strap_done_reg <= strap_done_next;
      strap_wait_reg <= strap_wait_next;
      mode_i2c_reg <= mode_i2c_next;
      addr_reg <= addr_next;
    end
  end

  // Select low frames an SPI transaction
  assign selected = strap_done_reg & (mode_i2c_reg | ~pin_s[CCP_PIN_ADDR0]);

  // Serial clock edges and data sample
  always_comb begin
    sclk_d_next = pin_s[CCP_PIN_SCLK];
    serial_in_next = pin_s[CCP_PIN_DATA];
  end

  // Serial sampling registers
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      sclk_d_reg <= 1'h0;
      serial_in_reg <= 1'h0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      serial_in_reg <= serial_in_next;
    end
  end

  // Edge strobes only while selected: select pin low in SPI, always once straps are caught in I2C
  assign o_sclk_rise = selected & pin_s[CCP_PIN_SCLK] & ~sclk_d_reg;
  assign o_sclk_fall = selected & ~pin_s[CCP_PIN_SCLK] & sclk_d_reg;

  // Pin drive steering by protocol
  always_comb begin
    data_out_next = 1'h0;
    data_oe_next = 1'h0;
    so_out_next = 1'h0;
    so_oe_next = 1'h0;
    if (!strap_done_reg) begin
      data_oe_next = 1'h0;
    end else if (mode_i2c_reg) begin
      data_oe_next = i_tx_en & ~i_tx_bit;
      so_oe_next = 1'h0;
    end else if (i_spi_four_wire) begin
      so_out_next = i_tx_bit;
      so_oe_next = i_tx_en & selected;
      data_oe_next = 1'h0;
    end else begin
      data_out_next = i_tx_bit;
      data_oe_next = i_tx_en & selected;
    end
  end

  // Pin drive registers
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      data_out_reg <= 1'h0;
      data_oe_reg <= 1'h0;
      so_out_reg <= 1'h0;
      so_oe_reg <= 1'h0;
    end else begin
      data_out_reg <= data_out_next;
      data_oe_reg <= data_oe_next;
      so_out_reg <= so_out_next;
      so_oe_reg <= so_oe_next;
    end
  end

  // Status vector and change detection
  assign stat_now = {i_pll_locked, i_input_lost};
  assign status_event = stat_valid_reg & (stat_now != stat_reg);

  // Sticky interrupt, a new change beats a clear
  always_comb begin
    stat_next = stat_now;
    stat_valid_next = 1'h1;
    irq_next = irq_reg;
    if (i_irq_clear) begin
      irq_next = 1'h0;
    end
    if (status_event) begin
      irq_next = 1'h1;
    end
  end

  // Status registers
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      stat_reg <= CCP_STAT_RST;
      stat_valid_reg <= 1'h0;
      irq_reg <= 1'h0;
    end else begin
      stat_reg <= stat_next;
      stat_valid_reg <= stat_valid_next;
      irq_reg <= irq_next;
    end
  end

  // Clock outputs gated by reset and disable pin, off until pins are valid
  always_comb begin
    outs_next = CCP_OUTS_OFF;
    if (strap_done_reg && !pin_s[CCP_PIN_ODIS]) begin
      outs_next = i_out_cfg_enable;
    end
  end

  // Output enable register, off during reset
  always_ff @(posedge i_clk or posedge core_rst) begin
    if (core_rst) begin
      outs_reg <= CCP_OUTS_OFF;
    end else begin
      outs_reg <= outs_next;
    end
  end

  // Pin outputs
  assign o_serial_data = data_out_reg;
  assign o_serial_data_oe = data_oe_reg;
  assign o_addr_one_or_serial_out = so_out_reg;
  assign o_addr_one_or_serial_out_oe = so_oe_reg;

  // Core side outputs
  assign o_bus_is_i2c = mode_i2c_reg;
  assign o_i2c_addr_pins = addr_reg;
  assign o_spi_selected = selected & ~mode_i2c_reg;
  assign o_serial_in = serial_in_reg;
  assign o_core_reset = core_rst;
  assign o_clk_out_enable = outs_reg;

  // Status pins, lock and loss from registered status
  assign o_status_change_irq_n = ~irq_reg;
  assign o_lock_ok_indicator = stat_valid_reg & stat_reg[CCP_STAT_LOCK_BIT];
  assign o_input0_signal_loss_n = ~(stat_valid_reg & stat_reg[0]);
  assign o_input1_signal_loss_n = ~(stat_valid_reg & stat_reg[1]);
  assign o_input2_signal_loss_n = ~(stat_valid_reg & stat_reg[2]);

endmodule : ccp_pin_ctrl
`default_nettype wire

// [verilog/ccp_pkg.sv]
// Constants shared by the clock chip control and status pin block
`default_nettype none
package ccp_pkg;
  // Synchroniser depth for every pin input
  localparam int CCP_SYNC_STAGES = 2;
  // Number of loss-of-signal indicators
  localparam int CCP_NUM_LOS = 3;
  // Number of clock output enables
  localparam int CCP_NUM_OUTS = 10;
  // Width of the hardware address pin pair
  localparam int CCP_ADDR_PINS = 2;
  // Strap level that selects the I2C host protocol
  localparam logic CCP_STRAP_I2C = 1'h1;
  // Status vector: lock bit above the loss bits
  localparam int CCP_STAT_W = CCP_NUM_LOS + 1;
  localparam int CCP_STAT_LOCK_BIT = CCP_NUM_LOS;
  // Pin synchroniser bit positions
  localparam int CCP_PIN_STRAP = 0;
  localparam int CCP_PIN_DATA = 1;
  localparam int CCP_PIN_ADDR1 = 2;
  localparam int CCP_PIN_SCLK = 3;
  localparam int CCP_PIN_ADDR0 = 4;
  localparam int CCP_PIN_ODIS = 5;
  localparam int CCP_NUM_PINS = 6;
  // Reset values
  localparam logic [1:0] CCP_RST_SYNC_INIT = 2'h3;
  localparam logic [CCP_NUM_PINS-1:0] CCP_PIN_RST = 6'h00;
  localparam logic [CCP_ADDR_PINS-1:0] CCP_ADDR_RST = 2'h0;
  localparam logic [CCP_STAT_W-1:0] CCP_STAT_RST = 4'h0;
  localparam logic [CCP_NUM_OUTS-1:0] CCP_OUTS_OFF = 10'h000;
  localparam logic [CCP_NUM_LOS-1:0] CCP_LOS_RST = 3'h0;
endpackage : ccp_pkg
`default_nettype wire

// [tb/ccp_host_model.sv]
// Host controller model driving the serial clock, select and data pins
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
  // Clock and frame control
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_hold_sel,
  // Serial pins
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_sdi
);
  int cnt = 0;
  initial begin
    o_sclk = 1'h0;
    o_sel_n = 1'h1;
    o_sdi = 1'h0;
  end
  // Frame of four clock pulses, clock still outside frames
  always @(posedge i_clk) begin
    if (i_go && cnt == 0) cnt <= 40;
    else if (cnt != 0) cnt <= cnt - 1;
    o_sel_n <= #1 (cnt == 0) || i_hold_sel;
    o_sclk <= #1 (cnt >= 4) && (cnt < 36) && cnt[2];
    o_sdi <= #1 cnt[3];
  end
endmodule : ccp_host_model
`default_nettype wire

// [tb/ccp_pin_ctrl_sva.sv]
// Assertions on the control and status pin block
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_ctrl_sva
  import ccp_pkg::*;
(
  // Watched inputs
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_device_reset_n,
  input wire logic i_outputs_disable,
  input wire logic i_spi_four_wire,
  input wire logic i_tx_bit,
  input wire logic i_tx_en,
  input wire logic [CCP_NUM_OUTS-1:0] i_out_cfg_enable,
  input wire logic i_pll_locked,
  input wire logic [CCP_NUM_LOS-1:0] i_input_lost,
  input wire logic i_irq_clear,
  // Watched outputs
  input wire logic o_serial_data,
  input wire logic o_serial_data_oe,
  input wire logic o_addr_one_or_serial_out,
  input wire logic o_addr_one_or_serial_out_oe,
  input wire logic o_bus_is_i2c,
  input wire logic o_spi_selected,
  input wire logic o_sclk_rise,
  input wire logic o_sclk_fall,
  input wire logic o_core_reset,
  input wire logic [CCP_NUM_OUTS-1:0] o_clk_out_enable,
  input wire logic o_status_change_irq_n,
  input wire logic o_lock_ok_indicator,
  input wire logic o_input0_signal_loss_n,
  input wire logic o_input1_signal_loss_n,
  input wire logic o_input2_signal_loss_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Status path settled, then a status change
  sequence s_settled;
    !o_core_reset [*3];
  endsequence
  sequence s_changed;
    $changed(i_pll_locked) || $changed(i_input_lost);
  endsequence
  a_reset_outs_off: assert property (!i_device_reset_n |-> o_core_reset && o_clk_out_enable == '0)
    else $error("outputs on in reset");
  a_disable_off: assert property (i_outputs_disable [*4] |-> o_clk_out_enable == '0)
    else $error("outputs on while disabled");
  a_enable_runs: assert property ((!i_outputs_disable && !o_core_reset) [*5] |-> o_clk_out_enable == $past(i_out_cfg_enable))
    else $error("outputs not as configured");
  a_lock_follow: assert property (s_settled |-> o_lock_ok_indicator == $past(i_pll_locked))
    else $error("lock pin wrong");
  a_loss_follow: assert property (s_settled |->
    {o_input2_signal_loss_n, o_input1_signal_loss_n, o_input0_signal_loss_n} == ~$past(i_input_lost))
    else $error("loss pins wrong");
  a_irq_on_change: assert property (s_settled ##0 s_changed |-> ##[1:2] (!o_status_change_irq_n || o_core_reset))
    else $error("no interrupt on change");
  a_irq_sticky: assert property (!o_status_change_irq_n && !i_irq_clear |=> !o_status_change_irq_n || !i_device_reset_n)
    else $error("interrupt dropped");
  a_spi_quiet: assert property (!o_bus_is_i2c && !o_spi_selected |-> !o_sclk_rise && !o_sclk_fall)
    else $error("strobe while deselected");
  a_i2c_drive: assert property (o_bus_is_i2c && i_device_reset_n |=>
    o_serial_data_oe == ($past(i_tx_en) && !$past(i_tx_bit)) && !o_serial_data && !o_addr_one_or_serial_out_oe)
    else $error("bad open drain drive");
  a_sdo_drive: assert property (o_spi_selected && i_spi_four_wire && i_tx_en |=>
    o_addr_one_or_serial_out_oe && !o_serial_data_oe && o_addr_one_or_serial_out == $past(i_tx_bit))
    else $error("bad serial out drive");
endmodule : ccp_pin_ctrl_sva
bind ccp_pin_ctrl ccp_pin_ctrl_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_device_reset_n(i_device_reset_n),
  .i_outputs_disable(i_outputs_disable), .i_spi_four_wire(i_spi_four_wire), .i_tx_bit(i_tx_bit),
  .i_tx_en(i_tx_en), .i_out_cfg_enable(i_out_cfg_enable), .i_pll_locked(i_pll_locked),
  .i_input_lost(i_input_lost), .i_irq_clear(i_irq_clear), .o_serial_data(o_serial_data),
  .o_serial_data_oe(o_serial_data_oe), .o_addr_one_or_serial_out(o_addr_one_or_serial_out),
  .o_addr_one_or_serial_out_oe(o_addr_one_or_serial_out_oe), .o_bus_is_i2c(o_bus_is_i2c),
  .o_spi_selected(o_spi_selected), .o_sclk_rise(o_sclk_rise), .o_sclk_fall(o_sclk_fall),
  .o_core_reset(o_core_reset), .o_clk_out_enable(o_clk_out_enable), .o_status_change_irq_n(o_status_change_irq_n),
  .o_lock_ok_indicator(o_lock_ok_indicator), .o_input0_signal_loss_n(o_input0_signal_loss_n),
  .o_input1_signal_loss_n(o_input1_signal_loss_n), .o_input2_signal_loss_n(o_input2_signal_loss_n));
`default_nettype wire

// [tb/ccp_pin_ctrl_tb.sv]
// Self-checking bench for the control and status pin block
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_ctrl_tb;
  import ccp_pkg::*;
  logic i_clk = 1'h0, i_rst = 1'h1, rst_n = 1'h1, strap = 1'h1, a1 = 1'h0, a0 = 1'h0, odis = 1'h0;
  logic four = 1'h0, tx_bit = 1'h1, tx_en = 1'h0, go = 1'h0, hold = 1'h0, clr = 1'h0, locked = 1'h0;
  logic h_sclk, h_sel_n, h_sdi, sd, sd_oe, ao, ao_oe, is_i2c, core_rst, irq_n, lock, sin, spi_sel;
  logic [2:0] lost = 3'h0, loss_n;
  logic [1:0] apins;
  logic [9:0] cfg = 10'h2a5, en;
  int err_count = 0, num_checks = 0, n_rise = 0, n_fall = 0;
  // Rows: locked, lost[2:0], expected lock pin, expected loss pins
  logic [7:0] rows [5] = '{8'h8f, 8'h9e, 8'h25, 8'hcb, 8'hf8};
  logic rise, fall;
  // Clock
  always #5 i_clk = ~i_clk;
  // Host on the serial pins
  ccp_host_model u_host (.i_clk(i_clk), .i_go(go), .i_hold_sel(hold), .o_sclk(h_sclk), .o_sel_n(h_sel_n), .o_sdi(h_sdi));
  // Pins resolved: pull-up on data in I2C, board level on address pins
  ccp_pin_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_device_reset_n(rst_n), .i_i2c_select(strap), .i_sclk(h_sclk),
    .i_serial_data(sd_oe ? sd : (strap | h_sdi)), .o_serial_data(sd), .o_serial_data_oe(sd_oe),
    .i_addr_one_or_serial_out(ao_oe ? ao : a1), .o_addr_one_or_serial_out(ao), .o_addr_one_or_serial_out_oe(ao_oe),
    .i_addr_zero_or_select_n(strap ? a0 : h_sel_n), .i_outputs_disable(odis), .i_spi_four_wire(four),
    .i_tx_bit(tx_bit), .i_tx_en(tx_en), .o_bus_is_i2c(is_i2c), .o_i2c_addr_pins(apins), .o_spi_selected(spi_sel),
    .o_sclk_rise(rise), .o_sclk_fall(fall), .o_serial_in(sin), .o_core_reset(core_rst), .i_out_cfg_enable(cfg),
    .o_clk_out_enable(en), .i_pll_locked(locked), .i_input_lost(lost), .i_irq_clear(clr),
    .o_status_change_irq_n(irq_n), .o_lock_ok_indicator(lock), .o_input0_signal_loss_n(loss_n[0]),
    .o_input1_signal_loss_n(loss_n[1]), .o_input2_signal_loss_n(loss_n[2]));
  // Strobe counters
  always @(posedge i_clk) begin
    n_rise <= n_rise + int'(rise);
    n_fall <= n_fall + int'(fall);
  end
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task test_done;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Pin reset with straps set, outputs checked while held
  task boot(input logic s, input logic b1, input logic b0);
    strap = s;
    a1 = b1;
    a0 = b0;
    rst_n = 1'h0;
    cyc(3);
    chk("outputs", 10'h0, en);
    chk("reset view", 10'h37, 10'({core_rst, irq_n, lock, loss_n}));
    rst_n = 1'h1;
    cyc(8);
  endtask : boot
  // Watchdog
  initial begin
    #20000;
    err_count++;
    test_done;
  end
  // Main sequence
  initial begin
    cyc(3);
    i_rst = 1'h0;
    boot(1'h1, 1'h1, 1'h0);
    chk("mode", 10'h1, 10'(is_i2c));
    chk("addr pins", 10'h2, 10'(apins));
    chk("serial in", 10'h1, 10'(sin));
    foreach (rows[i]) begin
      {locked, lost} = rows[i][7:4];
      cyc(2);
      chk("status pins", 10'(rows[i][3:0]), 10'({lock, loss_n}));
      chk("irq", 10'h0, 10'(irq_n));
      clr = 1'h1;
      cyc(1);
      clr = 1'h0;
      cyc(1);
      chk("irq", 10'h1, 10'(irq_n));
    end
    odis = 1'h1;
    cyc(4);
    chk("outputs", 10'h0, en);
    odis = 1'h0;
    cyc(4);
    chk("outputs", cfg, en);
    tx_en = 1'h1;
    tx_bit = 1'h0;
    cyc(1);
    chk("i2c drive", 10'h4, 10'({sd_oe, sd, ao_oe}));
    tx_bit = 1'h1;
    cyc(1);
    chk("i2c drive", 10'h0, 10'({sd_oe, sd, ao_oe}));
    tx_en = 1'h0;
    boot(1'h0, 1'h0, 1'h0);
    chk("mode", 10'h0, 10'(is_i2c));
    chk("serial in", 10'h0, 10'(sin));
    hold = 1'h1;
    go = 1'h1;
    cyc(1);
    go = 1'h0;
    cyc(45);
    chk("strobes", 10'h0, 10'(n_rise));
    chk("spi select", 10'h0, 10'(spi_sel));
    hold = 1'h0;
    go = 1'h1;
    cyc(1);
    go = 1'h0;
    cyc(8);
    tx_en = 1'h1;
    cyc(1);
    chk("spi drive", 10'h6, 10'({sd_oe, sd, ao_oe}));
    chk("spi select", 10'h1, 10'(spi_sel));
    four = 1'h1;
    cyc(1);
    chk("spi drive", 10'h3, 10'({sd_oe, ao_oe, ao}));
    tx_bit = 1'h0;
    cyc(1);
    chk("spi drive", 10'h2, 10'({sd_oe, ao_oe, ao}));
    tx_en = 1'h0;
    cyc(40);
    chk("strobes", 10'h44, 10'({n_rise[3:0], n_fall[3:0]}));
    test_done;
  end
endmodule : ccp_pin_ctrl_tb
`default_nettype wire
